// *** include/channel_regs_pkg.sv ***
// Constants for the channel enable and output voltage register bank.
// Assumes one 250 MHz clock and an external serial engine driving the register port.
package channel_regs_pkg;

	//----------------------------------------------------------------
	// Register port
	//----------------------------------------------------------------
	localparam int          ADDR_W = 8;
	localparam int          DATA_W = 8;
	localparam int          NUM_CH = 5;
	localparam int          MV_W   = 13;
	localparam int          CYC_W  = 16;

	localparam logic [7:0]  ADDR_CTRL      = 8'h01;
	localparam logic [7:0]  ADDR_CH1_CODE  = 8'h02;
	localparam logic [7:0]  ADDR_CH23_CODE = 8'h03;
	localparam logic [7:0]  ADDR_CH4_CODE  = 8'h04;
	localparam logic [7:0]  ADDR_SCALING   = 8'h05;
	localparam logic [7:0]  READ_UNMAPPED  = 8'h00;

	//----------------------------------------------------------------
	// Reset values (code defaults stand in for the fuse-loaded ones)
	//----------------------------------------------------------------
	localparam logic [7:0]  CTRL_RESET      = 8'h1F;
	localparam logic [7:0]  CH1_CODE_RESET  = 8'h07;
	localparam logic [7:0]  CH23_CODE_RESET = 8'h11;
	localparam logic [7:0]  CH4_CODE_RESET  = 8'h09;
	localparam logic [7:0]  SCALING_RESET   = 8'h00;
	localparam logic [4:0]  ALL_CH          = 5'h1F;

	//----------------------------------------------------------------
	// Field positions
	//----------------------------------------------------------------
	localparam int          CH2_CODE_LSB     = 0;
	localparam int          CH3_CODE_LSB     = 4;
	localparam int          CH1_SCALE_EN_BIT = 2;
	localparam int          CH1_INTERVAL_LSB = 0;
	localparam int          CH4_SCALE_EN_BIT = 6;
	localparam int          CH4_INTERVAL_LSB = 4;

	//----------------------------------------------------------------
	// Output voltage mapping, millivolts
	//----------------------------------------------------------------
	localparam logic [12:0] ADJ_MV       = 13'd800;
	localparam logic [12:0] CH1_BASE_MV  = 13'd825;
	localparam logic [12:0] CH1_STEP_MV  = 13'd25;
	localparam logic [12:0] CH2_BASE_MV  = 13'd3000;
	localparam logic [12:0] CH2_STEP_MV  = 13'd300;
	localparam logic [12:0] CH2_TOP_MV   = 13'd5000;
	localparam logic [12:0] CH3_BASE_MV  = 13'd1100;
	localparam logic [12:0] CH3_STEP_MV  = 13'd100;
	localparam logic [12:0] CH4_BASE_MV  = 13'd2400;
	localparam logic [12:0] CH4_STEP_MV  = 13'd100;

	//----------------------------------------------------------------
	// Scaling step intervals
	//----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS    = 4;
	localparam int          INTERVAL0_NS     = 62500;
	localparam int          INTERVAL1_NS     = 31200;
	localparam int          INTERVAL2_NS     = 15600;
	localparam int          INTERVAL3_NS     = 7800;
	localparam int          INTERVAL0_CYCLES = INTERVAL0_NS / CLK_PERIOD_NS;
	localparam int          INTERVAL1_CYCLES = INTERVAL1_NS / CLK_PERIOD_NS;
	localparam int          INTERVAL2_CYCLES = INTERVAL2_NS / CLK_PERIOD_NS;
	localparam int          INTERVAL3_CYCLES = INTERVAL3_NS / CLK_PERIOD_NS;

endpackage : channel_regs_pkg

// *** rtl/voltage_code_decode.sv ***
// Maps the four buck voltage codes to target millivolts and adjustable flags.
// Assumes codes come straight from the register bank; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module voltage_code_decode (
	input  wire logic [4:0]                         i_ch1_code,
	input  wire logic [2:0]                         i_ch2_code,
	input  wire logic [2:0]                         i_ch3_code,
	input  wire logic [4:0]                         i_ch4_code,
	output logic      [channel_regs_pkg::MV_W-1:0]  o_ch1_mv,
	output logic      [channel_regs_pkg::MV_W-1:0]  o_ch2_mv,
	output logic      [channel_regs_pkg::MV_W-1:0]  o_ch3_mv,
	output logic      [channel_regs_pkg::MV_W-1:0]  o_ch4_mv,
	output logic      [3:0]                         o_adjustable
);
	import channel_regs_pkg::*;

	always_comb begin
		o_adjustable = {i_ch4_code == 5'h0, i_ch3_code == 3'h0,
		                i_ch2_code == 3'h0, i_ch1_code == 5'h0};
		o_ch1_mv = CH1_BASE_MV + CH1_STEP_MV * 13'(i_ch1_code);
		o_ch2_mv = CH2_BASE_MV + CH2_STEP_MV * 13'(i_ch2_code);
		o_ch3_mv = CH3_BASE_MV + CH3_STEP_MV * 13'(i_ch3_code);
		o_ch4_mv = CH4_BASE_MV + CH4_STEP_MV * 13'(i_ch4_code);
		if (i_ch2_code == 3'h7) begin
			o_ch2_mv = CH2_TOP_MV;
		end
		if (o_adjustable[0]) begin
			o_ch1_mv = ADJ_MV;
		end
		if (o_adjustable[1]) begin
			o_ch2_mv = ADJ_MV;
		end
		if (o_adjustable[2]) begin
			o_ch3_mv = ADJ_MV;
		end
		if (o_adjustable[3]) begin
			o_ch4_mv = ADJ_MV;
		end
	end

endmodule : voltage_code_decode

`default_nettype wire

// *** rtl/channel_enable_voltage_regs.sv ***
// Channel enable and output voltage register bank of a five channel power manager.
// Assumes a serial engine presents one-cycle read and write strobes, and enable pins
// already synchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none

module channel_enable_voltage_regs #(
	parameter int P_INTERVAL0_CYCLES = channel_regs_pkg::INTERVAL0_CYCLES
) (
	input  wire logic                                  i_mclk,
	input  wire logic                                  i_rst_n,
	input  wire logic                                  i_wr_en,
	input  wire logic                                  i_rd_en,
	input  wire logic [channel_regs_pkg::ADDR_W-1:0]   i_addr,
	input  wire logic [channel_regs_pkg::DATA_W-1:0]   i_wr_data,
	input  wire logic [channel_regs_pkg::NUM_CH-1:0]   i_channel_hw_enable_pin,
	output logic      [channel_regs_pkg::DATA_W-1:0]   o_rd_data,
	output logic      [channel_regs_pkg::NUM_CH-1:0]   o_channel_run,
	output logic      [channel_regs_pkg::MV_W-1:0]     o_ch1_target_mv,
	output logic      [channel_regs_pkg::MV_W-1:0]     o_ch2_target_mv,
	output logic      [channel_regs_pkg::MV_W-1:0]     o_ch3_target_mv,
	output logic      [channel_regs_pkg::MV_W-1:0]     o_ch4_target_mv,
	output logic      [3:0]                            o_adjustable,
	output logic                                       o_ch1_scaling_enable,
	output logic                                       o_ch4_scaling_enable,
	output logic      [channel_regs_pkg::CYC_W-1:0]    o_ch1_step_cycles,
	output logic      [channel_regs_pkg::CYC_W-1:0]    o_ch4_step_cycles
);
	import channel_regs_pkg::*;

	//----------------------------------------------------------------
	// Interval decode
	//----------------------------------------------------------------
	function automatic logic [CYC_W-1:0] interval_cycles(input logic [1:0] sel);
		logic [CYC_W-1:0] cyc;
		case (sel)
			2'b00:   cyc = CYC_W'(P_INTERVAL0_CYCLES);
			2'b01:   cyc = CYC_W'(INTERVAL1_CYCLES);
			2'b10:   cyc = CYC_W'(INTERVAL2_CYCLES);
			default: cyc = CYC_W'(INTERVAL3_CYCLES);
		endcase
		return cyc;
	endfunction : interval_cycles

	//----------------------------------------------------------------
	// Reset release
	//----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_n;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	//----------------------------------------------------------------
	// Register bank
	//----------------------------------------------------------------
	logic [7:0]        ctrl_reg, ctrl_next;
	logic [7:0]        ch1_code_reg, ch1_code_next;
	logic [7:0]        ch23_code_reg, ch23_code_next;
	logic [7:0]        ch4_code_reg, ch4_code_next;
	logic [7:0]        scaling_reg, scaling_next;
	logic [7:0]        rd_data_reg, rd_data_next;
	logic [4:0]        run_reg, run_next;
	logic [MV_W-1:0]   dec_mv [4];
	logic [3:0]        dec_adj;
	logic [MV_W-1:0]   mv_reg [4];
	logic [3:0]        adj_reg;
	logic [1:0]        scale_en_reg, scale_en_next;
	logic [CYC_W-1:0]  step1_reg, step1_next;
	logic [CYC_W-1:0]  step4_reg, step4_next;

	voltage_code_decode u_decode (
		.i_ch1_code   (ch1_code_reg[4:0]),
		.i_ch2_code   (ch23_code_reg[CH2_CODE_LSB +: 3]),
		.i_ch3_code   (ch23_code_reg[CH3_CODE_LSB +: 3]),
		.i_ch4_code   (ch4_code_reg[4:0]),
		.o_ch1_mv     (dec_mv[0]),
		.o_ch2_mv     (dec_mv[1]),
		.o_ch3_mv     (dec_mv[2]),
		.o_ch4_mv     (dec_mv[3]),
		.o_adjustable (dec_adj)
	);

	always_comb begin
		ctrl_next    = ctrl_reg;
		ch1_code_next  = ch1_code_reg;
		ch23_code_next = ch23_code_reg;
		ch4_code_next  = ch4_code_reg;
		scaling_next = scaling_reg;
		rd_data_next = rd_data_reg;
		if (i_wr_en) begin
			case (i_addr)
				ADDR_CTRL: begin
					ctrl_next = {i_wr_data[7:5],
					             (i_wr_data[4:0] & i_channel_hw_enable_pin) |
					             (ctrl_reg[4:0] & ~i_channel_hw_enable_pin)};
				end
				ADDR_CH1_CODE:  ch1_code_next  = i_wr_data;
				ADDR_CH23_CODE: ch23_code_next = i_wr_data;
				ADDR_CH4_CODE:  ch4_code_next  = i_wr_data;
				ADDR_SCALING: scaling_next = i_wr_data;
				default: ;
			endcase
		end
		// Pin low reloads the default and wins over a same-cycle write
		ctrl_next[4:0] = ctrl_next[4:0] | ~i_channel_hw_enable_pin;
		if (i_rd_en) begin
			case (i_addr)
				ADDR_CTRL:    rd_data_next = ctrl_reg;
				ADDR_CH1_CODE:  rd_data_next = ch1_code_reg;
				ADDR_CH23_CODE: rd_data_next = ch23_code_reg;
				ADDR_CH4_CODE:  rd_data_next = ch4_code_reg;
				ADDR_SCALING: rd_data_next = scaling_reg;
				default:      rd_data_next = READ_UNMAPPED;
			endcase
		end
		run_next      = ctrl_reg[4:0] & i_channel_hw_enable_pin;
		scale_en_next = {scaling_reg[CH4_SCALE_EN_BIT], scaling_reg[CH1_SCALE_EN_BIT]};
		step1_next    = interval_cycles(scaling_reg[CH1_INTERVAL_LSB +: 2]);
		step4_next    = interval_cycles(scaling_reg[CH4_INTERVAL_LSB +: 2]);
	end

	always_ff @(posedge i_mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_reg     <= CTRL_RESET;
			ch1_code_reg  <= CH1_CODE_RESET;
			ch23_code_reg <= CH23_CODE_RESET;
			ch4_code_reg  <= CH4_CODE_RESET;
			scaling_reg  <= SCALING_RESET;
			rd_data_reg  <= 8'h00;
			run_reg      <= 5'h00;
			adj_reg      <= 4'h0;
			scale_en_reg <= 2'b00;
			step1_reg    <= '0;
			step4_reg    <= '0;
			for (int i = 0; i < 4; i++) begin
				mv_reg[i] <= '0;
			end
		end else begin
			ctrl_reg     <= ctrl_next;
			ch1_code_reg  <= ch1_code_next;
			ch23_code_reg <= ch23_code_next;
			ch4_code_reg  <= ch4_code_next;
			scaling_reg  <= scaling_next;
			rd_data_reg  <= rd_data_next;
			run_reg      <= run_next;
			adj_reg      <= dec_adj;
			scale_en_reg <= scale_en_next;
			step1_reg    <= step1_next;
			step4_reg    <= step4_next;
			for (int i = 0; i < 4; i++) begin
				mv_reg[i] <= dec_mv[i];
			end
		end
	end

	assign o_rd_data            = rd_data_reg;
	assign o_channel_run        = run_reg;
	assign o_ch1_target_mv      = mv_reg[0];
	assign o_ch2_target_mv      = mv_reg[1];
	assign o_ch3_target_mv      = mv_reg[2];
	assign o_ch4_target_mv      = mv_reg[3];
	assign o_adjustable         = adj_reg;
	assign o_ch1_scaling_enable = scale_en_reg[0];
	assign o_ch4_scaling_enable = scale_en_reg[1];
	assign o_ch1_step_cycles    = step1_reg;
	assign o_ch4_step_cycles    = step4_reg;

	//----------------------------------------------------------------
	// Checks
	//----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!rst_sync_n);

	reset_defaults_a: assert property ($rose(rst_sync_n) |->
		ctrl_reg == CTRL_RESET && ch1_code_reg == CH1_CODE_RESET &&
		scaling_reg == SCALING_RESET)
		else $error("bank not at defaults after reset");
	soft_default_a: assert property ($rose(rst_sync_n) |-> ctrl_reg[4:0] == ALL_CH)
		else $error("soft enables not one after reset");
	run_and_a: assert property (rst_sync_n |=> o_channel_run ==
		($past(ctrl_reg[4:0]) & $past(i_channel_hw_enable_pin)))
		else $error("run is not soft enable and pin");
	write_gate_a: assert property ((i_wr_en && i_addr == ADDR_CTRL &&
		i_channel_hw_enable_pin == ALL_CH) |=> ctrl_reg == $past(i_wr_data))
		else $error("control write lost with pins high");
	pin_reload_a: assert property (1'b1 |=>
		(ctrl_reg[4:0] | $past(i_channel_hw_enable_pin)) == ALL_CH)
		else $error("low pin did not reload soft enable");
	readback_a: assert property ((i_rd_en && i_addr == ADDR_CTRL) |=>
		o_rd_data == $past(ctrl_reg))
		else $error("control readback wrong");
	vid_store_a: assert property ((i_wr_en && i_addr == ADDR_CH1_CODE) |=>
		ch1_code_reg == $past(i_wr_data))
		else $error("channel 1 code not stored");
	ch1_adjust_a: assert property (ch1_code_reg[4:0] == 5'h00 |=>
		o_adjustable[0] && o_ch1_target_mv == 13'd800)
		else $error("channel 1 adjustable mode wrong");
	ch1_step_a: assert property (rst_sync_n && ch1_code_reg[4:0] == 5'h07 |=>
		o_ch1_target_mv == 13'd1000)
		else $error("channel 1 step wrong");
	ch1_first_a: assert property (ch1_code_reg[4:0] == 5'h01 |=>
		o_ch1_target_mv == 13'd850)
		else $error("channel 1 first code wrong");
	ch3_top_a: assert property (ch23_code_reg[6:4] == 3'h7 |=>
		o_ch3_target_mv == 13'd1800)
		else $error("channel 3 top code wrong");
	ch2_top_a: assert property (ch23_code_reg[2:0] == 3'h7 |=>
		o_ch2_target_mv == 13'd5000)
		else $error("channel 2 top code wrong");
	ch4_map_a: assert property (ch4_code_reg[4:0] == 5'h1A |=>
		o_ch4_target_mv == 13'd5000 && !o_adjustable[3])
		else $error("channel 4 code map wrong");
	scale_field_a: assert property (scaling_reg[5:4] == 2'b11 |=>
		o_ch4_step_cycles == 16'd1950)
		else $error("channel 4 interval wrong");
	scale_off_a: assert property ($rose(rst_sync_n) |=>
		!o_ch1_scaling_enable && !o_ch4_scaling_enable)
		else $error("scaling enabled after reset");
	reserved_a: assert property ((i_wr_en && i_addr == ADDR_CH23_CODE) |=>
		ch23_code_reg[7] == $past(i_wr_data[7]) && ch23_code_reg[3] == $past(i_wr_data[3]))
		else $error("reserved bits not stored");

endmodule : channel_enable_voltage_regs

`default_nettype wire

// *** tb/host_model.sv ***
// Host model for the register port: single-byte reads and writes.
// Assumes the bank shares i_mclk and that requests start after reset.
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_rd_data,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wr_data
);
	initial begin
		o_wr_en   = 1'b0;
		o_rd_en   = 1'b0;
		o_addr    = 8'h00;
		o_wr_data = 8'h00;
	end

	// One strobe per byte; address and data scrambled while idle
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge i_mclk);
		#1;
		o_wr_en   = wr;
		o_rd_en   = ~wr;
		o_addr    = a;
		o_wr_data = d;
		@(posedge i_mclk);
		#1;
		q         = i_rd_data;
		o_wr_en   = 1'b0;
		o_rd_en   = 1'b0;
		o_addr    = ~a;
		o_wr_data = ~d;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// *** tb/channel_enable_voltage_regs_tb.sv ***
// Self-checking bench for the channel enable and voltage register bank.
// Assumes the host model drives the register port; pins driven here.
`timescale 1ns/1ps
`default_nettype none

module channel_enable_voltage_regs_tb;
	import channel_regs_pkg::*;
	logic        mclk, rst_n, wr_en, rd_en, sc1, sc4;
	logic [7:0]  addr, wr_data, rd_data;
	logic [4:0]  pins, run;
	logic [12:0] mv1, mv2, mv3, mv4;
	logic [3:0]  adj;
	logic [15:0] st1, st4;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	// Step cycles for interval codes 0..3 (15625, 7800, 3900, 1950)
	logic [15:0] cyc [4] = '{16'h3D09, 16'h1E78, 16'h0F3C, 16'h079E};

	channel_enable_voltage_regs u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data), .i_channel_hw_enable_pin(pins),
		.o_rd_data(rd_data), .o_channel_run(run), .o_ch1_target_mv(mv1),
		.o_ch2_target_mv(mv2), .o_ch3_target_mv(mv3), .o_ch4_target_mv(mv4),
		.o_adjustable(adj), .o_ch1_scaling_enable(sc1), .o_ch4_scaling_enable(sc4),
		.o_ch1_step_cycles(st1), .o_ch4_step_cycles(st4));
	host_model u_host (.i_mclk(mclk), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_rd_en(rd_en),
		.o_addr(addr), .o_wr_data(wr_data));

	always #2 mclk = ~mclk;

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Millivolts: 800 adjustable, 5000 for channel 2 code 7, else base plus step times code
	function automatic logic [12:0] mv(input int ch, input logic [4:0] c);
		if (c == 5'h00) return 13'h0320;
		case (ch)
			1: return 13'h0339 + 13'h0019 * c;
			2: return (c == 5'h07) ? 13'h1388 : 13'h0BB8 + 13'h012C * c;
			3: return 13'h044C + 13'h0064 * c;
			default: return 13'h0960 + 13'h0064 * c;
		endcase
	endfunction : mv

	task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_byte

	task automatic cmp_val(input string what, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_val

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.xfer(1'b1, a, d, q);
		repeat (2) @(posedge mclk);
		#1;
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_host.xfer(1'b0, a, 8'h00, q);
		cmp_byte(what, e, q);
	endtask : rd_chk

	task automatic do_reset;
		@(posedge mclk);
		#1;
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
	endtask : do_reset

	task automatic results;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic check_defaults(input logic [4:0] p);
		rd_chk("ctrl", ADDR_CTRL, 8'h1F);
		rd_chk("ch1_code", ADDR_CH1_CODE, CH1_CODE_RESET);
		rd_chk("ch23_code", ADDR_CH23_CODE, CH23_CODE_RESET);
		rd_chk("ch4_code", ADDR_CH4_CODE, CH4_CODE_RESET);
		rd_chk("scaling", ADDR_SCALING, 8'h00);
		rd_chk("unmapped", 8'h00, 8'h00);
		cmp_val("run", 16'(p), 16'(run));
		cmp_val("scale_en", 16'h0000, {14'h0000, sc1, sc4});
		cmp_val("step", {cyc[0]}, st4);
		cmp_val("ch1_mv", 16'(mv(1, CH1_CODE_RESET[4:0])), 16'(mv1));
		cmp_val("ch4_mv", 16'(mv(4, CH4_CODE_RESET[4:0])), 16'(mv4));
	endtask : check_defaults

	task automatic t_enables;
		wr(ADDR_CTRL, 8'hE0);
		rd_chk("ctrl_rsvd", ADDR_CTRL, 8'hE0);
		cmp_val("run_off", 16'h0000, 16'(run));
		pins = 5'h1E;
		repeat (2) @(posedge mclk);
		#1;
		rd_chk("ctrl_forced", ADDR_CTRL, 8'hE1);
		wr(ADDR_CTRL, 8'h00);
		rd_chk("ctrl_refused", ADDR_CTRL, 8'h01);
		wr(ADDR_CTRL, 8'h1F);
		cmp_val("run_and", 16'h001E, 16'(run));
		pins = 5'h1F;
		wr(ADDR_CTRL, 8'h15);
		cmp_val("run_mix", 16'h0015, 16'(run));
	endtask : t_enables

	task automatic t_ch1;
		for (int c = 0; c < 32; c++) begin
			wr(ADDR_CH1_CODE, {3'b101, 5'(c)});
			cmp_val("ch1_mv", 16'(mv(1, 5'(c))), 16'(mv1));
			cmp_val("ch1_adj", 16'(c == 0), 16'(adj[0]));
		end
		rd_chk("ch1_code_rsvd", ADDR_CH1_CODE, 8'hBF);
	endtask : t_ch1

	task automatic t_ch23;
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_CH23_CODE, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
			cmp_val("ch3_mv", 16'(mv(3, 5'(c))), 16'(mv3));
			cmp_val("ch2_mv", 16'(mv(2, 5'(7 - c))), 16'(mv2));
			cmp_val("ch23_adj", {14'h0000, c == 0, c == 7}, {14'h0000, adj[2:1]});
		end
		rd_chk("ch23_code_rsvd", ADDR_CH23_CODE, 8'hF8);
	endtask : t_ch23

	task automatic t_ch4;
		for (int c = 0; c < 32; c++) begin
			wr(ADDR_CH4_CODE, {3'b110, 5'(c)});
			cmp_val("ch4_mv", 16'(mv(4, 5'(c))), 16'(mv4));
			cmp_val("ch4_adj", 16'(c == 0), 16'(adj[3]));
		end
		rd_chk("ch4_code_rsvd", ADDR_CH4_CODE, 8'hDF);
	endtask : t_ch4

	task automatic t_scaling;
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_SCALING, {1'b0, ~k[0], 2'(k), 1'b1, k[0], 2'(3 - k)});
			cmp_val("ch1_step", cyc[3 - k], st1);
			cmp_val("ch4_step", cyc[k], st4);
			cmp_val("scale_en", {14'h0000, k[0], ~k[0]}, {14'h0000, sc1, sc4});
		end
		rd_chk("scaling_rb", ADDR_SCALING, 8'h3C);
	endtask : t_scaling

	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		results();
	end

	initial begin
		mclk  = 1'b0;
		rst_n = 1'b0;
		pins  = 5'h1F;
		do_reset();
		check_defaults(5'h1F);
		t_enables();
		t_ch1();
		t_ch23();
		t_ch4();
		t_scaling();
		pins = 5'h0A;
		do_reset();
		check_defaults(5'h0A);
		results();
	end
endmodule : channel_enable_voltage_regs_tb
`default_nettype wire
